// *** rtl/spif_defs.vh ***
`ifndef SPIF_DEFS_VH
`define SPIF_DEFS_VH
// ==========================================
// register byte offsets
`define SPIF_ADDR_MODE     8'h00
`define SPIF_ADDR_MASK     8'h04
`define SPIF_ADDR_PINSEL   8'h08
`define SPIF_ADDR_STAT     8'h0c
// ==========================================
// reset values
`define SPIF_RST_MODE      16'h0000
`define SPIF_RST_MASK      16'hffff
`define SPIF_RST_PINSEL    14'h3fff
// ==========================================
// serial_if_mode_cfg fields
`define SPIF_F_TYPE_LO     0
`define SPIF_F_TYPE_HI     1
`define SPIF_F_MUX1        2
`define SPIF_F_MUX2        3
`define SPIF_F_MUX3        4
`define SPIF_F_TEST_LO     5
`define SPIF_F_TEST_HI     6
`define SPIF_F_DRT_LO      7
`define SPIF_F_DRT_HI      8
`define SPIF_F_B1RT_LO     9
`define SPIF_F_B1RT_HI     10
`define SPIF_F_B2RT_LO     11
`define SPIF_F_B2RT_HI     12
// shared multiplexed interface types
`define SPIF_TYPE_HIGHWAY  2'h0
`define SPIF_TYPE_LINK     2'h1
`define SPIF_TYPE_GCBUS    2'h2
// test modes
`define SPIF_TEST_NONE     2'h0
`define SPIF_TEST_ECHO     2'h1
`define SPIF_TEST_LOOP     2'h2
// ==========================================
// pin order inside one controller's group of seven
`define SPIF_PIN_TXD       0
`define SPIF_PIN_TCLK      1
`define SPIF_PIN_RXD       2
`define SPIF_PIN_RCLK      3
`define SPIF_PIN_RTS       4
`define SPIF_PIN_CTS       5
`define SPIF_PIN_CD        6
// ==========================================
// frame layout, 10-bit link variant
`define SPIF_FRAME_BITS    20
`define SPIF_LAST_BIT      5'h13
`define SPIF_B1_FIRST      5'h00
`define SPIF_B1_LAST       5'h07
`define SPIF_D1_POS        5'h08
`define SPIF_M_POS         5'h09
`define SPIF_B2_FIRST      5'h0a
`define SPIF_B2_LAST       5'h11
`define SPIF_D2_POS        5'h12
`define SPIF_A_POS         5'h13
// ==========================================
// timing
`define SPIF_CLK_MHZ       50
`define SPIF_FRAME_US      125
`endif

// *** rtl/spif_regs.v ***
`include "spif_defs.vh"

module spif_regs (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // register contents
  output reg  [15:0] mode_ff,
  output reg  [15:0] mask_ff,
  output reg  [13:0] pinsel_ff,
  input  wire [15:0] status
);

  // ==========================================
  // decode
  wire       setup   = psel & ~penable;
  wire       access  = psel & penable;
  wire       hit_md  = (paddr == `SPIF_ADDR_MODE);
  wire       hit_mk  = (paddr == `SPIF_ADDR_MASK);
  wire       hit_ps  = (paddr == `SPIF_ADDR_PINSEL);
  wire       hit_st  = (paddr == `SPIF_ADDR_STAT);
  wire       mapped  = hit_md | hit_mk | hit_ps | hit_st;
  reg [31:0] nxt_rd;

  assign pready = 1'b1;

  always @* begin
    nxt_rd = 32'h0000_0000;
    if (hit_md) nxt_rd = {16'h0000, mode_ff};
    if (hit_mk) nxt_rd = {16'h0000, mask_ff};
    if (hit_ps) nxt_rd = {18'h00000, pinsel_ff};
    if (hit_st) nxt_rd = {16'h0000, status};
  end

  // ==========================================
  // storage; writes take effect in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff   <= `SPIF_RST_MODE;
      mask_ff   <= `SPIF_RST_MASK;
      pinsel_ff <= `SPIF_RST_PINSEL;
      prdata    <= 32'h0000_0000;
      pslverr   <= 1'b0;
    end else begin
      if (setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : nxt_rd;
        pslverr <= ~mapped;
      end
      if (access & pwrite) begin
        if (hit_md) mode_ff   <= pwdata[15:0];
        if (hit_mk) mask_ff   <= pwdata[15:0];
        if (hit_ps) pinsel_ff <= pwdata[13:0];
      end
    end
  end

endmodule // spif_regs

// *** rtl/spif_top.v ***
`include "spif_defs.vh"
// Behaviour
// - four attachments: modem pins, highway, interchip link, general circuit bus; highway and bus types have no frame logic
// - each controller owns seven modem pins in non-multiplexed mode
// - second controller pins individually shared with parallel port lines
// - third controller data/clock pins to parallel port, handshakes to three-wire port
// - multiplexed interface uses first controller pins; first always joins
// - second and third may join the mux, freeing their own pins
// - baud clock on baud pin when non-multiplexed, on tclk pin when joined
// - only five join combinations; mux membership needs first controller
// - one shared mux type for every joined controller
// - echo mode retransmits the whole received link signal
// - loopback feeds own transmitted signal into serial controller receive path; management receive still samples link receive
// - five channels B1 B2 D A M in 20-bit frame per 125 us
// - device is link slave, timed only by link clock and sync
// - only the 10-bit link variant is supported
// - two B strobes active during unmasked B1/B2 bits
// - link transmit driven only in supported bits, released otherwise
// - link receive sampled only during the 20 frame bits
// - the 20 link clock periods after sync pulse form the frame
// - request output asks for D channel, grant input answers
// - frame control channels handled by the two management controllers
// - grant sampled at a sync seen while idle; D stops on grant drop, resumes after such a sync
// - D B1 B2 routable to any controller; M first mgmt, A second
// - B bits received and sent only where the mask enables them

module spif_top #(
  parameter FRAME_CYC = `SPIF_FRAME_US * `SPIF_CLK_MHZ
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // serial controllers, bit k is controller k
  input  wire [2:0]  ctrl_txd,
  input  wire [2:0]  ctrl_rts,
  input  wire [2:0]  ctrl_baud,
  input  wire [2:0]  ctrl_dreq,
  output reg  [2:0]  ctrl_rxd,
  output reg  [2:0]  ctrl_tclk,
  output reg  [2:0]  ctrl_rclk,
  output reg  [2:0]  ctrl_cts,
  output reg  [2:0]  ctrl_cd,
  output reg  [2:0]  ctrl_tx_take,
  output reg  [2:0]  ctrl_rx_vld,
  output reg         d_collision,
  // management controllers, bit 0 first, bit 1 second
  input  wire [1:0]  mgmt_txd,
  output reg  [1:0]  mgmt_rxd,
  output reg  [1:0]  mgmt_tx_take,
  output reg  [1:0]  mgmt_rx_vld,
  // modem pins, index controller*7 + pin
  input  wire [20:0] nm_pin_i,
  output reg  [20:0] nm_pin_o,
  output reg  [20:0] nm_pin_oe,
  output reg  [2:0]  baud_gen_out,
  // alternate owners: parallel port, three-wire port
  input  wire [20:0] alt_o,
  input  wire [20:0] alt_oe,
  output reg  [20:0] alt_i,
  // interchip link
  input  wire        link_clock_in,
  input  wire        link_frame_sync,
  input  wire        link_rx_in,
  output reg         link_tx_o,
  output reg         link_tx_oe,
  output reg         dchan_request,
  input  wire        dchan_grant,
  output reg         b_strobe_one,
  output reg         b_strobe_two
);

  // ==========================================
  // registers
  wire [15:0] mode_ff;
  wire [15:0] mask_ff;
  wire [13:0] pinsel_ff;
  wire [15:0] status;

  spif_regs u_regs (
    .pclk      (pclk),
    .presetn   (presetn),
    .paddr     (paddr),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .mode_ff   (mode_ff),
    .mask_ff   (mask_ff),
    .pinsel_ff (pinsel_ff),
    .status    (status)
  );

  // ==========================================
  // configuration decode
  wire [1:0] mux_type = mode_ff[`SPIF_F_TYPE_HI:`SPIF_F_TYPE_LO];
  wire [1:0] test_md  = mode_ff[`SPIF_F_TEST_HI:`SPIF_F_TEST_LO];
  wire [1:0] d_rt     = mode_ff[`SPIF_F_DRT_HI:`SPIF_F_DRT_LO];
  wire [1:0] b1_rt    = mode_ff[`SPIF_F_B1RT_HI:`SPIF_F_B1RT_LO];
  wire [1:0] b2_rt    = mode_ff[`SPIF_F_B2RT_HI:`SPIF_F_B2RT_LO];
  wire       mux_on   = mode_ff[`SPIF_F_MUX1];
  // others join only behind the first, giving the five combinations
  wire [2:0] joined   = {mux_on & mode_ff[`SPIF_F_MUX3],
                         mux_on & mode_ff[`SPIF_F_MUX2], mux_on};
  // one type serves every joined controller
  wire       link_md  = mux_on & (mux_type == `SPIF_TYPE_LINK);
  wire       echo_md  = (test_md == `SPIF_TEST_ECHO);
  wire       loop_md  = (test_md == `SPIF_TEST_LOOP);
  // pin owners: 1 = controller, 0 = alternate function
  wire [20:0] pin_own = {pinsel_ff[13:7], pinsel_ff[6:0], 7'h7f};

  // ==========================================
  // modem pin routing
  wire [20:0] nxt_pin_o;
  wire [20:0] nxt_pin_oe;
  wire [20:0] nxt_alt_i;
  genvar gi;
  generate
    for (gi = 0; gi < 21; gi = gi + 1) begin : g_pin
      localparam K = gi / 7;
      localparam J = gi % 7;
      // joined pins are free except tclk, which carries the baud clock
      wire own = pin_own[gi] & (~joined[K] | (J == `SPIF_PIN_TCLK)) &
                 ~(K == 0 && joined[0] && J != `SPIF_PIN_TCLK);
      wire cval = (J == `SPIF_PIN_TXD)  ? ctrl_txd[K] :
                  (J == `SPIF_PIN_RTS)  ? ctrl_rts[K] :
                  (J == `SPIF_PIN_TCLK) ? ctrl_baud[K] : 1'b0;
      wire coe  = (J == `SPIF_PIN_TXD) | (J == `SPIF_PIN_RTS) |
                  ((J == `SPIF_PIN_TCLK) & joined[K]);
      assign nxt_pin_o[gi]  = own ? cval : alt_o[gi];
      assign nxt_pin_oe[gi] = own ? coe : alt_oe[gi];
      assign nxt_alt_i[gi]  = own ? 1'b0 : nm_pin_i[gi];
    end
  endgenerate

  // ==========================================
  // link frame sequencer, all timing from link clock edges
  localparam ST_IDLE  = 3'b001;
  localparam ST_ARMED = 3'b010;
  localparam ST_FRAME = 3'b100;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg         lclk_ff;
  reg  [4:0]  idx_ff;
  reg  [4:0]  nxt_idx;
  reg  [4:0]  cur_ch_ff;
  reg  [3:0]  cur_pos_ff;
  reg  [1:0]  cur_rt_ff;
  reg         cur_en_ff;
  reg         gnt_ok_ff;
  reg         rx_last_ff;
  reg         sync_lost_ff;
  reg  [15:0] wd_ff;

  wire lrise = link_clock_in & ~lclk_ff;
  wire lfall = ~link_clock_in & lclk_ff;
  wire start = lrise & (state_ff[1] | (state_ff[2] & (idx_ff != `SPIF_LAST_BIT)));

  always @* begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    case (state_ff)
      ST_IDLE: begin
        if (lrise & link_md & link_frame_sync) nxt_state = ST_ARMED;
      end
      ST_ARMED: begin
        if (lrise) begin
          nxt_state = ST_FRAME;
          nxt_idx   = 5'h00;
        end
      end
      ST_FRAME: begin
        if (lrise) begin
          if (idx_ff == `SPIF_LAST_BIT)
            nxt_state = (link_md & link_frame_sync) ? ST_ARMED : ST_IDLE;
          else
            nxt_idx = idx_ff + 5'h01;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (!link_md) nxt_state = ST_IDLE;
  end

  // channel of the bit that starts: {b1, b2, d, m, a}
  reg [4:0] ch;
  reg [3:0] pos;
  always @* begin
    ch  = 5'h00;
    pos = 4'h0;
    if (nxt_idx <= `SPIF_B1_LAST) begin
      ch  = 5'h10;
      pos = {1'b0, nxt_idx[2:0]};
    end else if (nxt_idx == `SPIF_D1_POS || nxt_idx == `SPIF_D2_POS) begin
      ch = 5'h04;
    end else if (nxt_idx == `SPIF_M_POS) begin
      ch = 5'h02;
    end else if (nxt_idx <= `SPIF_B2_LAST) begin
      ch  = 5'h08;
      pos = 4'h8 + {1'b0, nxt_idx[2:0] - 3'h2};
    end else begin
      ch = 5'h01;
    end
  end

  // per-bit transmit decision
  reg  [1:0] rt;
  reg        en;
  reg        dbit;
  always @* begin
    rt   = 2'h0;
    en   = 1'b0;
    dbit = 1'b1;
    if (ch[4]) begin
      rt = b1_rt;
      en = mask_ff[pos] & joined[b1_rt];
    end else if (ch[3]) begin
      rt = b2_rt;
      en = mask_ff[pos] & joined[b2_rt];
    end else if (ch[2]) begin
      rt = d_rt;
      en = joined[d_rt];
    end else begin
      en = 1'b1;
    end
    if (ch[1]) dbit = mgmt_txd[0];
    else if (ch[0]) dbit = mgmt_txd[1];
    else dbit = ctrl_txd[rt];
  end

  wire d_go = gnt_ok_ff & dchan_grant & dchan_request;
  wire tx_en = en & (~ch[2] | d_go);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= ST_IDLE;
      lclk_ff      <= 1'b0;
      idx_ff       <= 5'h00;
      cur_ch_ff    <= 5'h00;
      cur_pos_ff   <= 4'h0;
      cur_rt_ff    <= 2'h0;
      cur_en_ff    <= 1'b0;
      gnt_ok_ff    <= 1'b0;
      rx_last_ff   <= 1'b1;
      sync_lost_ff <= 1'b0;
      wd_ff        <= 16'h0000;
      link_tx_o    <= 1'b1;
      link_tx_oe   <= 1'b0;
      dchan_request <= 1'b0;
      b_strobe_one <= 1'b0;
      b_strobe_two <= 1'b0;
      ctrl_tx_take <= 3'h0;
      ctrl_rx_vld  <= 3'h0;
      ctrl_rxd     <= 3'h0;
      mgmt_tx_take <= 2'h0;
      mgmt_rx_vld  <= 2'h0;
      mgmt_rxd     <= 2'h0;
      d_collision  <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      idx_ff        <= nxt_idx;
      lclk_ff       <= link_clock_in;
      dchan_request <= link_md & joined[d_rt] & ctrl_dreq[d_rt];
      ctrl_tx_take  <= 3'h0;
      ctrl_rx_vld   <= 3'h0;
      mgmt_tx_take  <= 2'h0;
      mgmt_rx_vld   <= 2'h0;
      d_collision   <= 1'b0;
      // missing sync watchdog over two frame periods
      if (lrise & link_frame_sync) begin
        wd_ff        <= 16'h0000;
        sync_lost_ff <= 1'b0;
      end else if (link_md && wd_ff < FRAME_CYC[15:0] + FRAME_CYC[15:0]) begin
        wd_ff <= wd_ff + 16'h0001;
      end else if (link_md) begin
        sync_lost_ff <= 1'b1;
      end
      if (lrise & state_ff[0] & link_frame_sync)
        gnt_ok_ff <= dchan_grant;
      if (start) begin
        cur_ch_ff    <= ch;
        cur_pos_ff   <= pos;
        cur_rt_ff    <= rt;
        cur_en_ff    <= en & ~echo_md;
        b_strobe_one <= ch[4] & mask_ff[pos];
        b_strobe_two <= ch[3] & mask_ff[pos];
        if (echo_md) begin
          link_tx_o  <= rx_last_ff;
          link_tx_oe <= 1'b1;
        end else begin
          link_tx_o  <= dbit;
          link_tx_oe <= tx_en;
          if (tx_en & ~ch[1] & ~ch[0]) ctrl_tx_take[rt] <= 1'b1;
          if (ch[1]) mgmt_tx_take[0] <= 1'b1;
          if (ch[0]) mgmt_tx_take[1] <= 1'b1;
        end
        if (ch[2] & gnt_ok_ff & ~dchan_grant) begin
          gnt_ok_ff   <= 1'b0;
          d_collision <= dchan_request;
        end
      end else if (lrise | ~link_md) begin
        link_tx_oe   <= 1'b0;
        b_strobe_one <= 1'b0;
        b_strobe_two <= 1'b0;
      end
      // sample mid-bit, only inside the frame
      if (lfall & state_ff[2]) begin
        rx_last_ff <= loop_md ? (link_tx_oe ? link_tx_o : 1'b1) : link_rx_in;
        if (cur_ch_ff[1]) begin
          mgmt_rxd[0]    <= link_rx_in;
          mgmt_rx_vld[0] <= 1'b1;
        end else if (cur_ch_ff[0]) begin
          mgmt_rxd[1]    <= link_rx_in;
          mgmt_rx_vld[1] <= 1'b1;
        end else if (cur_en_ff) begin
          ctrl_rxd[cur_rt_ff]    <= loop_md ? (link_tx_oe ? link_tx_o : 1'b1) : link_rx_in;
          ctrl_rx_vld[cur_rt_ff] <= 1'b1;
        end
      end
      // non-joined controllers see their own modem pins
      if (~joined[0]) ctrl_rxd[0] <= nm_pin_i[`SPIF_PIN_RXD];
      if (~joined[1]) ctrl_rxd[1] <= nm_pin_i[7 + `SPIF_PIN_RXD];
      if (~joined[2]) ctrl_rxd[2] <= nm_pin_i[14 + `SPIF_PIN_RXD];
    end
  end

  // ==========================================
  // modem pin and controller-side registers
  integer k;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nm_pin_o     <= 21'h000000;
      nm_pin_oe    <= 21'h000000;
      alt_i        <= 21'h000000;
      baud_gen_out <= 3'h0;
      ctrl_tclk    <= 3'h0;
      ctrl_rclk    <= 3'h0;
      ctrl_cts     <= 3'h0;
      ctrl_cd      <= 3'h0;
    end else begin
      nm_pin_o  <= nxt_pin_o;
      nm_pin_oe <= nxt_pin_oe;
      alt_i     <= nxt_alt_i;
      for (k = 0; k < 3; k = k + 1) begin
        baud_gen_out[k] <= joined[k] ? 1'b0 : ctrl_baud[k];
        ctrl_tclk[k] <= joined[k] ? link_clock_in : nm_pin_i[k*7 + `SPIF_PIN_TCLK];
        ctrl_rclk[k] <= joined[k] ? link_clock_in : nm_pin_i[k*7 + `SPIF_PIN_RCLK];
        ctrl_cts[k]  <= joined[k] ? 1'b0 : nm_pin_i[k*7 + `SPIF_PIN_CTS];
        ctrl_cd[k]   <= joined[k] ? 1'b0 : nm_pin_i[k*7 + `SPIF_PIN_CD];
      end
    end
  end

  assign status = {3'h0, idx_ff, state_ff, sync_lost_ff, joined[2:1],
                   dchan_request, gnt_ok_ff};

endmodule // spif_top

// *** testbench/spif_chk.sv ***
module spif_chk #(
  parameter FRAME_CYC = 6250
) (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // register bus
  input wire logic [7:0] paddr,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // controllers
  input wire logic [2:0] ctrl_baud,
  input wire logic [2:0] baud_gen_out,
  input wire logic [2:0] ctrl_tx_take,
  input wire logic [2:0] ctrl_rx_vld,
  input wire logic       d_collision,
  // link
  input wire logic       dchan_request,
  input wire logic       dchan_grant,
  input wire logic       link_clock_in,
  input wire logic       link_tx_oe,
  input wire logic       b_strobe_one,
  input wire logic       b_strobe_two
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================
  // link timing
  strobe_excl_a: assert property (!(b_strobe_one && b_strobe_two))
    else $error("both b strobes high");
  strobe_edge_a: assert property ($changed({b_strobe_one, b_strobe_two}) |-> link_clock_in)
    else $error("strobe moved off a link rise");
  oe_edge_a: assert property ($changed(link_tx_oe) |-> link_clock_in)
    else $error("tx enable moved off a link rise");
  take_edge_a: assert property (|ctrl_tx_take |-> link_clock_in && !$past(link_clock_in, 4))
    else $error("tx take not near a link rise");
  vld_edge_a: assert property (|ctrl_rx_vld |-> !link_clock_in && $past(link_clock_in, 4))
    else $error("rx valid not near a link fall");
  coll_grant_a: assert property (d_collision |-> !dchan_grant && $past(dchan_request))
    else $error("collision without grant drop");
  // ==========================================
  // baud clock and register bus
  baud_src_a: assert property ((baud_gen_out & ~$past(ctrl_baud)) == 3'b000)
    else $error("baud output without baud input");
  apb_err_a: assert property (psel && penable && paddr > 8'h0c |-> pslverr)
    else $error("unmapped access without error");
  apb_rdy_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
endmodule // spif_chk

bind spif_top spif_chk #(.FRAME_CYC(FRAME_CYC)) u_spif_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .ctrl_baud(ctrl_baud), .baud_gen_out(baud_gen_out),
  .ctrl_tx_take(ctrl_tx_take), .ctrl_rx_vld(ctrl_rx_vld), .d_collision(d_collision),
  .dchan_request(dchan_request), .dchan_grant(dchan_grant), .link_clock_in(link_clock_in),
  .link_tx_oe(link_tx_oe), .b_strobe_one(b_strobe_one), .b_strobe_two(b_strobe_two)
);

// *** testbench/spif_phy_model.sv ***
module spif_phy_model #(
  parameter int HALF = 4
) (
  // clock and bench controls
  input  wire logic        pclk,
  input  wire logic        go,
  input  wire logic        g_hi,
  input  wire logic        g_cut,
  input  wire logic [19:0] rx_pat,
  // link wires from the device
  input  wire logic        link_tx_o,
  input  wire logic        link_tx_oe,
  input  wire logic        b_strobe_one,
  input  wire logic        b_strobe_two,
  // link wires to the device
  output logic             link_clock_in = 1'b0,
  output logic             link_frame_sync = 1'b0,
  output logic             link_rx_in = 1'b1,
  output logic             dchan_grant = 1'b1,
  // frame capture
  output logic             busy = 1'b0,
  output logic [19:0]      seen_tx,
  output logic [19:0]      seen_oe,
  output logic [19:0]      seen_s1,
  output logic [19:0]      seen_s2
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // one frame: sync rise, 20 bit rises, closing rise; clock idles low
  always @(posedge pclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      for (int k = 0; k < 22; k++) begin
        repeat (HALF) @(posedge pclk);
        link_clock_in <= 1'b1;
        link_frame_sync <= (k == 0);
        link_rx_in <= (k > 0 && k < 21) ? rx_pat[k-1] : 1'b1;
        dchan_grant <= g_hi && !(g_cut && k > 12);
        repeat (HALF) @(posedge pclk);
        link_clock_in <= 1'b0;
        link_frame_sync <= 1'b0;
        if (k > 0 && k < 21) begin
          // released line reads high through the pull-up
          seen_tx[k-1] <= link_tx_oe ? link_tx_o : 1'b1;
          seen_oe[k-1] <= link_tx_oe;
          seen_s1[k-1] <= b_strobe_one;
          seen_s2[k-1] <= b_strobe_two;
        end
      end
      busy <= 1'b0;
    end
  end
endmodule // spif_phy_model

// *** testbench/tb_top.sv ***
`include "spif_defs.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic        pready, pslverr, err_q;
  logic [2:0]  ctrl_txd = 3'b010, ctrl_rts = 3'b000, ctrl_baud = 3'b000, ctrl_dreq = 3'b000;
  logic [2:0]  ctrl_rxd, ctrl_tx_take, ctrl_rx_vld, baud_gen_out;
  logic [1:0]  mgmt_txd = 2'b00;
  logic [20:0] nm_pin_i = 21'h0, nm_pin_o, alt_o = 21'h0, alt_oe = 21'h0, alt_i;
  logic        link_clock_in, link_frame_sync, link_rx_in, link_tx_o, link_tx_oe;
  logic        dchan_request, dchan_grant, b_strobe_one, b_strobe_two, d_collision;
  logic        go = 1'b0, g_hi = 1'b1, g_cut = 1'b0, busy;
  logic [19:0] rx_pat = 20'hfffff, seen_tx, seen_oe, seen_s1, seen_s2;
  logic [7:0]  rxsh = 8'h0;
  int          rxn, tkn, coll, cyc = 0, mismatches = 0, samples_checked = 0;

  spif_top #(.FRAME_CYC(200)) u_spif_top (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctrl_txd(ctrl_txd), .ctrl_rts(ctrl_rts), .ctrl_baud(ctrl_baud), .ctrl_dreq(ctrl_dreq),
    .ctrl_rxd(ctrl_rxd), .ctrl_tclk(), .ctrl_rclk(), .ctrl_cts(), .ctrl_cd(),
    .ctrl_tx_take(ctrl_tx_take), .ctrl_rx_vld(ctrl_rx_vld), .d_collision(d_collision),
    .mgmt_txd(mgmt_txd), .mgmt_rxd(), .mgmt_tx_take(), .mgmt_rx_vld(),
    .nm_pin_i(nm_pin_i), .nm_pin_o(nm_pin_o), .nm_pin_oe(), .baud_gen_out(baud_gen_out),
    .alt_o(alt_o), .alt_oe(alt_oe), .alt_i(alt_i), .link_clock_in(link_clock_in),
    .link_frame_sync(link_frame_sync), .link_rx_in(link_rx_in), .link_tx_o(link_tx_o),
    .link_tx_oe(link_tx_oe), .dchan_request(dchan_request), .dchan_grant(dchan_grant),
    .b_strobe_one(b_strobe_one), .b_strobe_two(b_strobe_two)
  );

  spif_phy_model u_spif_phy_model (
    .pclk(pclk), .go(go), .g_hi(g_hi), .g_cut(g_cut), .rx_pat(rx_pat),
    .link_tx_o(link_tx_o), .link_tx_oe(link_tx_oe), .b_strobe_one(b_strobe_one),
    .b_strobe_two(b_strobe_two), .link_clock_in(link_clock_in),
    .link_frame_sync(link_frame_sync), .link_rx_in(link_rx_in), .dchan_grant(dchan_grant),
    .busy(busy), .seen_tx(seen_tx), .seen_oe(seen_oe), .seen_s1(seen_s1), .seen_s2(seen_s2)
  );

  // ==========================================
  // clock, timeout and link monitors
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
    if (ctrl_rx_vld[1] === 1'b1) begin
      rxsh <= {rxsh[6:0], ctrl_rxd[1]};
      rxn <= rxn + 1;
    end
    if (ctrl_tx_take[1] === 1'b1) tkn <= tkn + 1;
    if (d_collision === 1'b1) coll <= coll + 1;
  end

  // ==========================================
  // access and check tasks
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd_q, e);
  endtask

  task automatic frame(input logic [19:0] pat, input logic hi, input logic cut);
    rx_pat <= pat;
    g_hi <= hi;
    g_cut <= cut;
    rxn = 0;
    tkn = 0;
    coll = 0;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do @(posedge pclk); while (busy !== 1'b0);
  endtask

  // b bits follow the mask; d bits per grant; m and a left out
  task automatic fchk(input logic [15:0] mk, input logic d);
    logic [19:0] e;
    e = {1'b0, d, mk[15:8], 1'b0, d, mk[7:0]};
    chk("tx_oe", 32'(seen_oe & 20'h7fdff), 32'(e));
    chk("strobe1", 32'(seen_s1), 32'(mk[7:0]));
    chk("strobe2", 32'(seen_s2), 32'({mk[15:8], 10'h0}));
    chk("tx_b", 32'(seen_tx & e & 20'h3fcff), 32'(mk[7:0]));
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("mode_rst", `SPIF_ADDR_MODE, 32'(`SPIF_RST_MODE));
    rdchk("mask_rst", `SPIF_ADDR_MASK, 32'(`SPIF_RST_MASK));
    rdchk("pinsel_rst", `SPIF_ADDR_PINSEL, 32'(`SPIF_RST_PINSEL));
    rdchk("unmapped", 8'h10, 32'h0);
    chk("unmapped_err", 32'(err_q), 32'h1);
    apb(1'b1, `SPIF_ADDR_PINSEL, 32'hffffffff);
    rdchk("pinsel_rsv", `SPIF_ADDR_PINSEL, 32'h3fff);
    ctrl_baud <= 3'b101;
    nm_pin_i <= 21'h050204;
    repeat (3) @(posedge pclk);
    chk("nm_rxd", 32'(ctrl_rxd), 32'h7);
    chk("baud_nm", 32'(baud_gen_out), 32'h5);
    chk("alt_none", 32'(alt_i), 32'h0);
    apb(1'b1, `SPIF_ADDR_PINSEL, 32'h37fb);
    repeat (3) @(posedge pclk);
    chk("alt_own", 32'(alt_i), 32'h40200);
    ctrl_baud <= 3'b111;
    for (int i = 0; i < 8; i++) begin
      logic [2:0] jx;
      jx = i[0] ? i[2:0] : 3'b000;
      apb(1'b1, `SPIF_ADDR_MODE, {27'h0, i[2:0], 2'b00});
      repeat (3) @(posedge pclk);
      chk("baud_join", 32'(baud_gen_out), {29'h0, ~jx});
      if (jx[1]) chk("tclk_baud", 32'(nm_pin_o[8]), 32'h1);
      rdchk("status", `SPIF_ADDR_STAT, {24'h0, 3'h1, 1'b0, jx[2:1], 2'b00});
      chk("joined", 32'(rd_q[3:2]), 32'(jx[2:1]));
    end
    apb(1'b1, `SPIF_ADDR_MASK, 32'h26c0);
    apb(1'b1, `SPIF_ADDR_MODE, 32'h031d);
    frame(20'h00040, 1'b1, 1'b0);
    fchk(16'h26c0, 1'b0);
    chk("rx_n", rxn, 2);
    chk("rx_bits", 32'(rxsh[1:0]), 32'h2);
    chk("take_n", tkn, 2);
    apb(1'b1, `SPIF_ADDR_MODE, 32'h035d);
    frame(20'h0, 1'b1, 1'b0);
    fchk(16'h26c0, 1'b0);
    chk("loop_bits", 32'(rxsh[1:0]), 32'h3);
    apb(1'b1, `SPIF_ADDR_MODE, 32'h033d);
    frame(20'h5a5a5, 1'b1, 1'b0);
    chk("echo_oe", 32'(seen_oe), 32'hfffff);
    chk("echo_tx", 32'(seen_tx[19:1]), 32'h5a5a5 & 32'h7ffff);
    apb(1'b1, `SPIF_ADDR_MODE, 32'h031d);
    ctrl_dreq <= 3'b100;
    repeat (3) @(posedge pclk);
    chk("d_request", 32'(dchan_request), 32'h1);
    for (int i = 0; i < 4; i++) begin
      frame(20'h0, i != 2, i == 1);
      chk("d_oe", 32'({seen_oe[18], seen_oe[8]}), i == 1 ? 1 : i == 2 ? 0 : 3);
      chk("collision", coll, 32'(i == 1));
    end
    summarize();
  end
endmodule // tb_top
